// ==== hw/pkfet_pkg.sv ====
// constants, register map, state types and carriers for the fet protection block
// Summary of operation
// - overvoltage, overtemperature or prolonged overcurrent sets charge fault, charge fet off
// - charge fet stays on while discharge current exceeds 50 mA
// - charge fet back on when causes gone; prolonged overcurrent also needs avg below 256 mA
// - overdischarge or avg at or below minus overload sets discharge fault, fet off
// - discharge fet stays on while charge current is 50 mA or more
// - discharge fet back on when overdischarge gone; overload also needs avg above -256 mA
// - after a front end trip, release it once average current is 0 mA
// - voltage decisions may need two successive agreeing measurements, by config bit
// - safety output low also sets the safety tripped status bit
// - safety output and tripped bit latch until power-on reset
// - charge fault plus pack voltage over safety limit for 1 s trips safety
// - charge fault plus temperature over safety limit for 1 s trips safety
// - front end failures trip safety when check bit 5 set and count reaches limit
// - front end registers checked every check time seconds, times sleep setting asleep
// - every failed front end check increments the failure counter, which saturates at 255
// - charge fault from voltage, fast-charge current, cell overvoltage or overtemp bit
package pkfet_pkg;
    localparam int          CLK_HZ          = 125_000_000;
    localparam int          SAFETY_TIME_S   = 1;
    localparam int          SEC_CYCLES_DFLT = CLK_HZ * SAFETY_TIME_S;
    localparam int          I2C_KHZ         = 100;
    localparam int          I2C_QTR_CYCLES  = CLK_HZ / (I2C_KHZ * 1000 * 4);
    localparam logic [15:0] DSG_OVR_MA      = 16'h0032;
    localparam logic [15:0] CHG_OVR_MA      = 16'h0032;
    localparam logic [15:0] RECOVER_MA      = 16'h0100;
    localparam logic [6:0]  AFE_I2C_ADDR    = 7'h08;
    localparam logic [7:0]  AFE_FET_REG     = 8'h04;
    localparam int          FD_DSG_OFF      = 0;
    localparam int          FD_CHG_OFF      = 1;
    localparam int          FD_TRIP_CLR     = 2;
    localparam logic [11:0] A_CTRL          = 12'h000;
    localparam logic [11:0] A_STATUS        = 12'h004;
    localparam logic [11:0] A_CHG_V_LIM     = 12'h008;
    localparam logic [11:0] A_FAST_I_LIM    = 12'h00c;
    localparam logic [11:0] A_CELL_OV       = 12'h010;
    localparam logic [11:0] A_SAFE_OV       = 12'h014;
    localparam logic [11:0] A_SAFE_TEMP     = 12'h018;
    localparam logic [11:0] A_OVL_I         = 12'h01c;
    localparam logic [11:0] A_FAIL_LIM      = 12'h020;
    localparam logic [11:0] A_CHK_TIME      = 12'h024;
    localparam logic [11:0] A_SLP_TIME      = 12'h028;
    localparam logic [11:0] A_FAIL_CNT      = 12'h02c;
    localparam int          CB_DOUBLE       = 0;
    localparam int          CB_SLEEP        = 1;
    localparam int          CB_AFE_CHECK    = 5;
    localparam logic [15:0] LIM_RESET       = 16'hffff;
    localparam logic [7:0]  FAIL_LIM_RESET  = 8'h03;
    localparam logic [7:0]  CHK_TIME_RESET  = 8'h0a;
    localparam logic [7:0]  SLP_TIME_RESET  = 8'h01;
    typedef enum logic [1:0] {I2C_IDLE, I2C_START, I2C_BIT, I2C_STOP} pkfet_i2c_e;
    typedef struct packed {
        logic [15:0] voltage;
        logic [15:0] current;
        logic [15:0] avg_current;
        logic [15:0] temperature;
        logic [15:0] max_cell;
        logic        overtemp;
        logic        overdischarged;
    } pkfet_meas_s;
    typedef struct packed {
        logic        done;
        logic        ok;
    } pkfet_check_s;
endpackage

// ==== hw/pkfet_top.sv ====
// fet protection control: faults, front end commands, safety output, apb registers
`timescale 1ns/1ps
`default_nettype none
module pkfet_top #(
    parameter int SEC_CYCLES = pkfet_pkg::SEC_CYCLES_DFLT
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire pkfet_pkg::pkfet_meas_s  meas,
    input  wire logic               meas_valid,
    input  wire logic               afe_alert_in,
    output logic                    afe_check_req,
    input  wire pkfet_pkg::pkfet_check_s afe_check,
    input  wire logic               scl_in,
    output logic                    scl_out,
    output logic                    scl_oe,
    input  wire logic               sda_in,
    output logic                    sda_out,
    output logic                    sda_oe,
    output logic                    safe_n,
    output logic                    chg_fet_off,
    output logic                    dsg_fet_off
);
    typedef struct packed {
        logic [2:0]  ctrl;
        logic [15:0] chg_v;
        logic [15:0] fast_i;
        logic [15:0] cell_ov;
        logic [15:0] safe_ov;
        logic [15:0] safe_t;
        logic [15:0] ovl_i;
        logic [7:0]  fail_lim;
        logic [7:0]  chk_time;
        logic [7:0]  slp_time;
        logic [7:0]  fail_cnt;
        logic        ov_prev;
        logic        od_prev;
        logic        ov_conf;
        logic        od_conf;
        logic        cf;
        logic        df;
        logic        poc_cause;
        logic        ol_cause;
        logic [26:0] ov_tmr;
        logic [26:0] ot_tmr;
        logic [26:0] sec_cnt;
        logic [15:0] chk_sec;
        logic        chk_req;
        logic        safe_n;
        logic        safety_tripped_flag;
        logic        alert_d;
        logic        trip_pend;
        logic        rel_req;
        logic [7:0]  sent;
        pkfet_pkg::pkfet_i2c_e st;
        logic [8:0]  qdiv;
        logic [1:0]  ph;
        logic [4:0]  bitcnt;
        logic [26:0] shreg;
        logic        nack;
        logic        scl_oe;
        logic        sda_oe;
        logic        lvl;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        chg_off;
        logic        dsg_off;
    } pkfet_state_s;

    pkfet_state_s s_reg;
    pkfet_state_s s_next;

    localparam logic [26:0] SEC_LAST = 27'(SEC_CYCLES - 1);
    localparam logic [8:0]  QTR_LAST = 9'(pkfet_pkg::I2C_QTR_CYCLES - 1);

    function automatic logic sge(input logic [15:0] a, input logic [15:0] b);
        sge = $signed(a) >= $signed(b);
    endfunction

    function automatic logic [26:0] tmr_step(input logic cond, input logic [26:0] t);
        if (!cond) begin
            tmr_step = 27'h0;
        end else if (t == SEC_LAST) begin
            tmr_step = t;
        end else begin
            tmr_step = t + 27'h1;
        end
    endfunction

    logic        acc;
    logic        ov_raw;
    logic        od_raw;
    logic        ov_now;
    logic        od_now;
    logic        poc;
    logic        ovl;
    logic        cf_set;
    logic        df_set;
    logic [15:0] chk_period;
    logic [7:0]  desired;
    logic        q_tick;
    logic        ack_bit;
    logic        afe_fail;

    always_comb begin
        s_next = s_reg;
        acc = psel && penable && s_reg.pready;
        // apb: one wait state, answer registered
        s_next.pready = psel && penable && !s_reg.pready;
        // error stands with pready only, never lingers
        s_next.pslverr = 1'b0;
        if (psel && penable && !s_reg.pready) begin
            s_next.prdata = 32'h0;
            case (paddr)
                pkfet_pkg::A_CTRL:       s_next.prdata[5:0] = {s_reg.ctrl[2], 3'h0, s_reg.ctrl[1:0]};
                pkfet_pkg::A_STATUS:     s_next.prdata[7:0] = {s_reg.nack, s_reg.trip_pend,
                                             s_reg.dsg_off, s_reg.chg_off, s_reg.safety_tripped_flag,
                                             s_reg.df, s_reg.cf, 1'b0};
                pkfet_pkg::A_CHG_V_LIM:  s_next.prdata[15:0] = s_reg.chg_v;
                pkfet_pkg::A_FAST_I_LIM: s_next.prdata[15:0] = s_reg.fast_i;
                pkfet_pkg::A_CELL_OV:    s_next.prdata[15:0] = s_reg.cell_ov;
                pkfet_pkg::A_SAFE_OV:    s_next.prdata[15:0] = s_reg.safe_ov;
                pkfet_pkg::A_SAFE_TEMP:  s_next.prdata[15:0] = s_reg.safe_t;
                pkfet_pkg::A_OVL_I:      s_next.prdata[15:0] = s_reg.ovl_i;
                pkfet_pkg::A_FAIL_LIM:   s_next.prdata[7:0] = s_reg.fail_lim;
                pkfet_pkg::A_CHK_TIME:   s_next.prdata[7:0] = s_reg.chk_time;
                pkfet_pkg::A_SLP_TIME:   s_next.prdata[7:0] = s_reg.slp_time;
                pkfet_pkg::A_FAIL_CNT:   s_next.prdata[7:0] = s_reg.fail_cnt;
                default:                 s_next.pslverr = 1'b1;
            endcase
        end
        if (acc && pwrite) begin
            case (paddr)
                pkfet_pkg::A_CTRL: begin
                    s_next.ctrl = {pwdata[pkfet_pkg::CB_AFE_CHECK],
                                   pwdata[pkfet_pkg::CB_SLEEP],
                                   pwdata[pkfet_pkg::CB_DOUBLE]};
                end
                pkfet_pkg::A_CHG_V_LIM:  s_next.chg_v = pwdata[15:0];
                pkfet_pkg::A_FAST_I_LIM: s_next.fast_i = pwdata[15:0];
                pkfet_pkg::A_CELL_OV:    s_next.cell_ov = pwdata[15:0];
                pkfet_pkg::A_SAFE_OV:    s_next.safe_ov = pwdata[15:0];
                pkfet_pkg::A_SAFE_TEMP:  s_next.safe_t = pwdata[15:0];
                pkfet_pkg::A_OVL_I:      s_next.ovl_i = pwdata[15:0];
                pkfet_pkg::A_FAIL_LIM:   s_next.fail_lim = pwdata[7:0];
                pkfet_pkg::A_CHK_TIME:   s_next.chk_time = pwdata[7:0];
                pkfet_pkg::A_SLP_TIME:   s_next.slp_time = pwdata[7:0];
                default: begin
                end
            endcase
        end

        // voltage decisions, optionally confirmed by two samples
        ov_raw = (meas.voltage >= s_reg.chg_v) || (meas.max_cell >= s_reg.cell_ov);
        od_raw = meas.overdischarged;
        if (meas_valid) begin
            s_next.ov_prev = ov_raw;
            s_next.od_prev = od_raw;
            if (s_reg.ctrl[0]) begin
                // a lone noisy sample neither trips nor clears
                if (ov_raw == s_reg.ov_prev) begin
                    s_next.ov_conf = ov_raw;
                end
                if (od_raw == s_reg.od_prev) begin
                    s_next.od_conf = od_raw;
                end
            end else begin
                s_next.ov_conf = ov_raw;
                s_next.od_conf = od_raw;
            end
        end
        ov_now = s_reg.ov_conf;
        od_now = s_reg.od_conf;

        // charge side
        poc = sge(meas.avg_current, s_reg.fast_i);
        cf_set = ov_now || meas.overtemp || poc;
        if (cf_set) begin
            s_next.cf = 1'b1;
            if (poc) begin
                s_next.poc_cause = 1'b1;
            end
        end else if (s_reg.cf && (!s_reg.poc_cause || !sge(meas.avg_current, pkfet_pkg::RECOVER_MA))) begin
            s_next.cf = 1'b0;
            s_next.poc_cause = 1'b0;
        end

        // discharge side
        ovl = !sge(meas.avg_current, 16'(-$signed(s_reg.ovl_i)) + 16'h0001);
        df_set = od_now || ovl;
        if (df_set) begin
            s_next.df = 1'b1;
            if (ovl) begin
                s_next.ol_cause = 1'b1;
            end
        end else if (s_reg.df && (!s_reg.ol_cause ||
                     sge(meas.avg_current, 16'(-$signed(pkfet_pkg::RECOVER_MA)) + 16'h0001))) begin
            s_next.df = 1'b0;
            s_next.ol_cause = 1'b0;
        end

        // direction overrides; otherwise front end owns the fet
        s_next.chg_off = s_reg.cf &&
            sge(meas.current, 16'(-$signed(pkfet_pkg::DSG_OVR_MA)));
        s_next.dsg_off = s_reg.df && !sge(meas.current, pkfet_pkg::CHG_OVR_MA);

        // front end stand-alone trip release
        s_next.alert_d = afe_alert_in;
        if (afe_alert_in && !s_reg.alert_d) begin
            s_next.trip_pend = 1'b1;
        end else if (s_reg.trip_pend && meas.avg_current == 16'h0000) begin
            s_next.trip_pend = 1'b0;
            s_next.rel_req = 1'b1;
        end

        // safety timers and latch
        s_next.ov_tmr = tmr_step(s_reg.cf && meas.voltage > s_reg.safe_ov, s_reg.ov_tmr);
        s_next.ot_tmr = tmr_step(s_reg.cf && meas.temperature > s_reg.safe_t, s_reg.ot_tmr);
        afe_fail = s_reg.ctrl[2] && s_reg.fail_cnt >= s_reg.fail_lim;
        if (s_reg.ov_tmr == SEC_LAST || s_reg.ot_tmr == SEC_LAST || afe_fail) begin
            s_next.safe_n = 1'b0;
            s_next.safety_tripped_flag = 1'b1;
        end
        // nothing releases these except reset

        // periodic front end register check
        chk_period = s_reg.ctrl[1] ? s_reg.chk_time * s_reg.slp_time
                                   : {8'h00, s_reg.chk_time};
        s_next.chk_req = 1'b0;
        if (s_reg.sec_cnt == SEC_LAST) begin
            s_next.sec_cnt = 27'h0;
            if (s_reg.chk_sec + 16'h0001 >= chk_period) begin
                s_next.chk_sec = 16'h0000;
                s_next.chk_req = 1'b1;
            end else begin
                s_next.chk_sec = s_reg.chk_sec + 16'h0001;
            end
        end else begin
            s_next.sec_cnt = s_reg.sec_cnt + 27'h1;
        end
        if (afe_check.done && !afe_check.ok && s_reg.fail_cnt != 8'hff) begin
            s_next.fail_cnt = s_reg.fail_cnt + 8'h01;
        end

        // i2c write of the fet command register
        desired = 8'h00;
        desired[pkfet_pkg::FD_DSG_OFF] = s_reg.dsg_off;
        desired[pkfet_pkg::FD_CHG_OFF] = s_reg.chg_off;
        q_tick = s_reg.qdiv == 9'h000;
        s_next.qdiv = q_tick ? QTR_LAST : s_reg.qdiv - 9'h001;
        ack_bit = s_reg.bitcnt == 5'h08 || s_reg.bitcnt == 5'h11 || s_reg.bitcnt == 5'h1a;
        case (s_reg.st)
            pkfet_pkg::I2C_IDLE: begin
                if (desired != s_reg.sent || s_reg.rel_req) begin
                    desired[pkfet_pkg::FD_TRIP_CLR] = s_reg.rel_req;
                    s_next.sent = {5'h00, 1'b0, desired[1:0]};
                    s_next.rel_req = 1'b0;
                    s_next.shreg = {pkfet_pkg::AFE_I2C_ADDR, 1'b0, 1'b1,
                                    pkfet_pkg::AFE_FET_REG, 1'b1, desired, 1'b1};
                    s_next.nack = 1'b0;
                    s_next.sda_oe = 1'b1;
                    s_next.qdiv = QTR_LAST;
                    s_next.st = pkfet_pkg::I2C_START;
                end
            end
            pkfet_pkg::I2C_START: begin
                if (q_tick) begin
                    s_next.scl_oe = 1'b1;
                    s_next.ph = 2'h0;
                    s_next.bitcnt = 5'h00;
                    s_next.st = pkfet_pkg::I2C_BIT;
                end
            end
            pkfet_pkg::I2C_BIT: begin
                if (q_tick) begin
                    s_next.ph = s_reg.ph + 2'h1;
                    case (s_reg.ph)
                        2'h0: s_next.sda_oe = !s_reg.shreg[26];
                        2'h1: s_next.scl_oe = 1'b0;
                        2'h2: s_next.nack = s_reg.nack || (ack_bit && sda_in && scl_in);
                        default: begin
                            s_next.scl_oe = 1'b1;
                            s_next.shreg = {s_reg.shreg[25:0], 1'b1};
                            s_next.bitcnt = s_reg.bitcnt + 5'h01;
                            if (s_reg.bitcnt == 5'h1a) begin
                                s_next.st = pkfet_pkg::I2C_STOP;
                            end
                        end
                    endcase
                end
            end
            pkfet_pkg::I2C_STOP: begin
                if (q_tick) begin
                    s_next.ph = s_reg.ph + 2'h1;
                    case (s_reg.ph)
                        2'h0: s_next.sda_oe = 1'b1;
                        2'h1: s_next.scl_oe = 1'b0;
                        2'h2: s_next.sda_oe = 1'b0;
                        default: s_next.st = pkfet_pkg::I2C_IDLE;
                    endcase
                end
            end
            default: s_next.st = pkfet_pkg::I2C_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.chg_v <= pkfet_pkg::LIM_RESET;
            s_reg.fast_i <= 16'h7fff;
            s_reg.cell_ov <= pkfet_pkg::LIM_RESET;
            s_reg.safe_ov <= pkfet_pkg::LIM_RESET;
            s_reg.safe_t <= pkfet_pkg::LIM_RESET;
            s_reg.ovl_i <= 16'h7fff;
            s_reg.fail_lim <= pkfet_pkg::FAIL_LIM_RESET;
            s_reg.chk_time <= pkfet_pkg::CHK_TIME_RESET;
            s_reg.slp_time <= pkfet_pkg::SLP_TIME_RESET;
            s_reg.safe_n <= 1'b1;
            s_reg.st <= pkfet_pkg::I2C_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata        = s_reg.prdata;
    assign pready        = s_reg.pready;
    assign pslverr       = s_reg.pslverr;
    assign afe_check_req = s_reg.chk_req;
    assign scl_out       = s_reg.lvl;
    assign scl_oe        = s_reg.scl_oe;
    assign sda_out       = s_reg.lvl;
    assign sda_oe        = s_reg.sda_oe;
    assign safe_n        = s_reg.safe_n;
    assign chg_fet_off   = s_reg.chg_off;
    assign dsg_fet_off   = s_reg.dsg_off;
endmodule
`default_nettype wire

// ==== hw/pkfet_unused_none.sv ====
// no further modules
`default_nettype none
`default_nettype wire

// ==== bench/pkfet_afe_model.sv ====
// front end model: open-drain receiver, acks every byte
`timescale 1ns/1ps
`default_nettype none
module pkfet_afe_model (
    input  wire logic       scl,
    input  wire logic       sda,
    output logic            ack_oe,
    output logic [7:0]      last_byte,
    output int              frames
);
    int         bit_n;
    logic [7:0] shreg;
    initial begin
        ack_oe = 1'b0;
        frames = 0;
        bit_n = 0;
        shreg = 8'h00;
        last_byte = 8'h00;
    end
    // start; first scl fall makes bit 0
    always @(negedge sda) if (scl) bit_n = -1;
    always @(posedge sda) if (scl) frames++;
    always @(posedge scl) if (bit_n >= 0 && bit_n < 8) shreg = {shreg[6:0], sda};
    // ack held from eighth fall to ninth
    always @(negedge scl) begin
        if (bit_n == 8) begin
            ack_oe = 1'b0;
            bit_n = 0;
        end else begin
            bit_n++;
            if (bit_n == 8) begin
                ack_oe = 1'b1;
                last_byte = shreg;
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/pkfet_top_chk.sv ====
// port checks for the fet protection block
`timescale 1ns/1ps
`default_nettype none
module pkfet_top_chk #(
    parameter int SEC_CYCLES = 20
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic [31:0]            prdata,
    input  wire logic                   pready,
    input  wire logic                   pslverr,
    input  wire pkfet_pkg::pkfet_meas_s meas,
    input  wire logic                   meas_valid,
    input  wire logic                   afe_check_req,
    input  wire logic                   safe_n,
    input  wire logic                   chg_fet_off,
    input  wire logic                   dsg_fet_off
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    safe_latch_a: assert property (!safe_n |=> !safe_n)
        else $error("safe released");
    chg_block_a: assert property (($signed(meas.current) < -16'sd50)[*3] |-> !chg_fet_off)
        else $error("chg off in dsg");
    dsg_block_a: assert property (($signed(meas.current) >= 16'sd50)[*3] |-> !dsg_fet_off)
        else $error("dsg off in chg");
    chg_fault_a: assert property ((meas.overtemp && !meas.current[15])[*3] |-> chg_fet_off)
        else $error("chg on in ot");
    dsg_fault_a: assert property ((meas.avg_current == 16'h8000
        && $signed(meas.current) < 16'sd50)[*3] |-> dsg_fet_off)
        else $error("dsg on in ovl");
    chg_release_a: assert property ((meas_valid && !meas.overtemp && meas.voltage == 16'h0
        && meas.max_cell == 16'h0 && meas.avg_current == 16'h0)[*6] |-> !chg_fet_off)
        else $error("chg not on");
    dsg_release_a: assert property ((meas_valid && !meas.overdischarged
        && meas.avg_current == 16'h0)[*6] |-> !dsg_fet_off)
        else $error("dsg not on");
    check_pulse_a: assert property (afe_check_req |=> !afe_check_req)
        else $error("check pulse long");
    apb_pulse_a: assert property (pready |=> !pready)
        else $error("ready long");
    err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error reply");
endmodule
bind pkfet_top pkfet_top_chk #(.SEC_CYCLES(SEC_CYCLES)) chk_u (.pclk(pclk), .presetn(presetn),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas), .meas_valid(meas_valid),
    .afe_check_req(afe_check_req), .safe_n(safe_n), .chg_fet_off(chg_fet_off),
    .dsg_fet_off(dsg_fet_off));
`default_nettype wire

// ==== bench/test_pkfet_top.sv ====
// testbench for the fet protection block
`timescale 1ns/1ps
`default_nettype none
module test_pkfet_top;
    localparam int SEC = 20;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, meas_valid;
    logic        afe_alert_in, afe_check_req, scl_out, scl_oe, sda_out, sda_oe, ack_oe;
    logic        safe_n, chg_fet_off, dsg_fet_off, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  last_byte;
    logic [15:0] volt;
    int          frames, fail_count, checks_done, n;
    wire logic   scl_w = !scl_oe;
    wire logic   sda_w = !(sda_oe || ack_oe);
    pkfet_pkg::pkfet_meas_s  meas;
    pkfet_pkg::pkfet_check_s afe_check;
    pkfet_top #(.SEC_CYCLES(SEC)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .meas(meas), .meas_valid(meas_valid),
        .afe_alert_in(afe_alert_in), .afe_check_req(afe_check_req), .afe_check(afe_check),
        .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .safe_n(safe_n), .chg_fet_off(chg_fet_off), .dsg_fet_off(dsg_fet_off));
    pkfet_afe_model afe_u (.scl(scl_w), .sda(sda_w), .ack_oe(ack_oe), .last_byte(last_byte),
        .frames(frames));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = !pclk;
    end
    task automatic give_verdict();
        if (fail_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // pready looked at mid-cycle, where it is settled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(negedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        q = prdata;
        e = pslverr;
        @(posedge pclk);
        {psel, penable} <= 2'b00;
        if (k >= 50) cmp("apb ready", 1, 0);
    endtask
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(nm, exp, q);
    endtask
    // f is {overtemp, overdischarged}; voltage from volt
    task automatic set_m(input logic [15:0] c, a, input logic [1:0] f, input int k);
        meas <= '{volt, c, a, 16'h0, 16'h0, f[1], f[0]};
        cyc(k);
    endtask
    task automatic reset_dut();
        presetn <= 1'b0;
        cyc(20);
        presetn <= 1'b1;
    endtask
    task automatic t_regs();
        rd("ctrl", pkfet_pkg::A_CTRL, 32'h0);
        rd("fail lim", pkfet_pkg::A_FAIL_LIM, 32'h3);
        rd("chk time", pkfet_pkg::A_CHK_TIME, 32'ha);
        rd("cell ov", pkfet_pkg::A_CELL_OV, 32'hffff);
        apb(1'b0, 12'h0f0, 32'h0);
        cmp("pslverr", 1, e);
        apb(1'b1, pkfet_pkg::A_STATUS, 32'hff);
        rd("status ro", pkfet_pkg::A_STATUS, 32'h0);
        apb(1'b1, pkfet_pkg::A_CHG_V_LIM, 32'h1000);
        apb(1'b1, pkfet_pkg::A_FAST_I_LIM, 32'h200);
    endtask
    task automatic t_charge();
        set_m(16'h0, 16'h0, 2'b10, 4);
        cmp("chg off ot", 1, chg_fet_off);
        rd("status cf", pkfet_pkg::A_STATUS, 32'h12);
        n = frames;
        for (int i = 0; i < 50000 && frames == n; i++) cyc(1);
        cmp("fet byte", 8'h02, last_byte);
        set_m(16'h0, 16'h0, 2'b00, 6);
        cmp("chg on ot gone", 0, chg_fet_off);
        set_m(16'hff9c, 16'h0300, 2'b00, 4);
        cmp("chg on in dsg", 0, chg_fet_off);
        set_m(16'h0, 16'h0300, 2'b00, 4);
        cmp("chg off poc", 1, chg_fet_off);
        set_m(16'h0, 16'h0100, 2'b00, 4);
        cmp("chg held 256", 1, chg_fet_off);
        set_m(16'h0, 16'h00ff, 2'b00, 4);
        cmp("chg on 255", 0, chg_fet_off);
        apb(1'b1, pkfet_pkg::A_CTRL, 32'h1);
        meas_valid <= 1'b0;
        volt = 16'h2000;
        set_m(16'h0, 16'h0, 2'b00, 0);
        for (int i = 0; i < 2; i++) begin
            cyc(1);
            meas_valid <= 1'b1;
            cyc(1);
            meas_valid <= 1'b0;
            cyc(4);
            cmp("double ov", i, chg_fet_off);
        end
        volt = 16'h0;
        set_m(16'h0, 16'h0, 2'b00, 0);
        meas_valid <= 1'b1;
        apb(1'b1, pkfet_pkg::A_CTRL, 32'h0);
        cyc(4);
        cmp("chg on ov gone", 0, chg_fet_off);
    endtask
    task automatic t_dsg();
        set_m(16'h0, 16'h8000, 2'b00, 4);
        cmp("dsg off ovl", 1, dsg_fet_off);
        rd("status df", pkfet_pkg::A_STATUS, 32'h24);
        set_m(16'h003c, 16'h8000, 2'b00, 4);
        cmp("dsg on in chg", 0, dsg_fet_off);
        set_m(16'h0, 16'hff00, 2'b00, 4);
        cmp("dsg held -256", 1, dsg_fet_off);
        set_m(16'h0, 16'hff01, 2'b00, 4);
        cmp("dsg on -255", 0, dsg_fet_off);
        set_m(16'h0, 16'h0, 2'b01, 4);
        cmp("dsg off od", 1, dsg_fet_off);
        set_m(16'h0, 16'h0, 2'b00, 6);
        cmp("dsg on od gone", 0, dsg_fet_off);
    endtask
    task automatic t_trip();
        set_m(16'h0, 16'h0005, 2'b00, 2);
        afe_alert_in <= 1'b1;
        cyc(3);
        rd("trip pend", pkfet_pkg::A_STATUS, 32'h40);
        afe_alert_in <= 1'b0;
        set_m(16'h0, 16'h0, 2'b00, 3);
        rd("trip clr", pkfet_pkg::A_STATUS, 32'h0);
    endtask
    task automatic t_safe_v();
        apb(1'b1, pkfet_pkg::A_SAFE_OV, 32'h100);
        volt = 16'h0200;
        set_m(16'h0, 16'h0, 2'b10, SEC - 4);
        cmp("safe early", 1, safe_n);
        cyc(10);
        cmp("safe 1 s", 0, safe_n);
        volt = 16'h0;
        set_m(16'h0, 16'h0, 2'b00, 8);
        cmp("safe latch", 0, safe_n);
        rd("sov bit", pkfet_pkg::A_STATUS, 32'h8);
        reset_dut();
        cmp("safe por", 1, safe_n);
    endtask
    // k: cycles to the next check request
    task automatic await_req(output int k);
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (afe_check_req !== 1'b1 && k < 2000);
        cyc(1);
    endtask
    task automatic t_safe_afe();
        apb(1'b1, pkfet_pkg::A_SLP_TIME, 32'h2);
        apb(1'b1, pkfet_pkg::A_CTRL, 32'h2);
        await_req(n);
        await_req(n);
        cmp("sleep period", pkfet_pkg::CHK_TIME_RESET * 2 * SEC, n);
        apb(1'b1, pkfet_pkg::A_FAIL_LIM, 32'h2);
        apb(1'b1, pkfet_pkg::A_CTRL, 32'h20);
        for (int i = 0; i < 3; i++) begin
            await_req(n);
            afe_check <= '{1'b1, i == 1};
            cyc(1);
            afe_check <= '{1'b0, 1'b0};
            cyc(3);
            cmp("safe afe", i != 2, safe_n);
            rd("fail cnt", pkfet_pkg::A_FAIL_CNT, (i == 2) ? 2 : 1);
        end
    endtask
    initial begin
        repeat (80000) @(posedge pclk);
        fail_count++;
        give_verdict();
    end
    initial begin
        fail_count = 0;
        checks_done = 0;
        {psel, penable, pwrite, paddr, pwdata, afe_alert_in} = '0;
        meas = '0;
        volt = 16'h0;
        meas_valid = 1'b1;
        afe_check = '0;
        presetn = 1'b0;
        reset_dut();
        t_regs();
        t_charge();
        t_dsg();
        t_trip();
        t_safe_v();
        t_safe_afe();
        give_verdict();
    end
endmodule
`default_nettype wire
